// ---- shared/clkgen_pkg.sv ----
// Shared constants and types for the clock generator control block
package clkgen_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FILT_UP = 8'h08;
  localparam logic [7:0] OFS_FILT_LO = 8'h0c;
  localparam logic [7:0] OFS_TRIM    = 8'h10;
  // Control register fields
  localparam int CTRL_CMS_LSB  = 0;
  localparam int CTRL_OSTEN    = 2;
  localparam int CTRL_RFD_LSB  = 4;
  // Status register fields
  localparam int STAT_DCO_STABLE_FLAG     = 0;
  localparam int STAT_EXT_REF_STABLE_FLAG     = 1;
  localparam int STAT_LOSS_OF_CLOCK_FLAG     = 2;
  localparam int STAT_CMST_LSB = 6;
  // Clock mode select and state codes
  localparam logic [1:0] CMS_SCM = 2'h0;
  localparam logic [1:0] CMS_FEI = 2'h1;
  localparam logic [1:0] CMS_FBE = 2'h2;
  localparam logic [1:0] CMS_FEE = 2'h3;
  // Reset values
  localparam logic [1:0]  CMS_RST    = 2'h0;
  localparam logic [2:0]  RFD_RST    = 3'h0;
  localparam logic [11:0] FILT_RST   = 12'h800;
  localparam logic [7:0]  TRIM_POR   = 8'h80;
  // Timing counts
  localparam logic [12:0] XTAL_COUNT = 13'h1000;
  localparam logic [2:0]  FLT_SETTLE = 3'h4;
  localparam logic [15:0] N_UNLOCK   = 16'h0010;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {M_SCM, M_FEI, M_FBE, M_FEE, M_OFF} mode_type;

  typedef struct packed {
    mode_type    mode;
    logic        from_off;
    logic [1:0]  cms;
    logic        osten;
    logic [2:0]  reduced_divider;
    logic [7:0]  trim;
    logic [11:0] filt;
    logic [7:0]  filt_lo_stage;
    logic [2:0]  flt_busy;
    logic        dco_stable_flag;
    logic [1:0]  good_cnt;
    logic [15:0] prev_err;
    logic [12:0] xtal_cnt;
    logic        locked_once;
    logic [1:0]  st_sync1;
    logic [1:0]  st_sync2;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_type;
endpackage : clkgen_pkg

// ---- rtl/clkgen_ctrl.sv ----
// Clock generator mode control, filter, trim and register slave
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - Set dco stable after two successive in-window error samples with toggling DIGITAL_OSC.
// - Clear dco stable flag on entering the off state.
// - In self-clocked mode, monitor DIGITAL_OSC for loss only after it is stable.
// - 12-bit filter split upper 3:0, lower 7:0; writable only when mode select is 00.
// - In self-clocked select, an upper filter write commits all twelve bits.
// - Upper filter write ignored while a previous latch sequence is unfinished.
// - Trim field adjusts reference period, binary weighted, larger means longer.
// - Trim register survives MCU reset.
// - Stop without debug or oscillator-in-stop stops all clocks, enters off.
// - Debug enabled during stop keeps clocks running as programmed.
// - Oscillator-in-stop keeps generators running, gates clock feed to the chip.
// - Interrupt wake keeps settings; external engaged runs self-clocked until external and DIGITAL_OSC are stable.
// - Interrupt wake into bypassed external runs self-clocked until the external stable flag sets.
// - Reset wake loads defaults, self-clocked at nominal DIGITAL_OSC, trim kept.
// - With a crystal, count 4096 reference clocks before engaging external reference.
// - Self-clocked entered on reset, off exit, X1 to 00, or lost reference.
// - Self-clocked: loop open, DIGITAL_OSC on, output is DIGITAL_OSC over reduced divider.
// - Reset gives nominal DIGITAL_OSC, other entries keep it; unlocked external exit doubles output.
// - Off exit with select 01 or 11 waits for stable DIGITAL_OSC, then closes loop.
// - Mode state reports 00 SELF_CLOCKED_MODE, 01 FLL_ENGAGED_INTERNAL, 10 FBE, 11 FEE after synchronisation.
// - Output divide factor is two to the power of reduced divider, doubled in FEE until the first lock.
module clkgen_ctrl
  import clkgen_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        POR_I,
  input  wire logic        STOP_I,
  input  wire logic        BDM_EN_I,
  input  wire logic        EXT_REF_STABLE_FLAG_I,
  input  wire logic        LOSS_OF_CLOCK_FLAG_I,
  input  wire logic        LOCK_I,
  input  wire logic        XTAL_I,
  input  wire logic        REF_EDGE_I,
  input  wire logic        SAMPLE_I,
  input  wire logic [15:0] COUNT_ERR_I,
  input  wire logic        DCO_ACTIVE_I,
  input  wire logic        LOOP_UPD_I,
  input  wire logic [11:0] LOOP_FILT_I,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [11:0]      FILTER_O,
  output logic [7:0]       TRIM_O,
  output logic             DCO_EN_O,
  output logic             REF_GEN_EN_O,
  output logic             SYS_CLK_EN_O,
  output logic             OUT_EN_O,
  output logic             REF_SEL_EXT_O,
  output logic             LOOP_CLOSED_O,
  output logic             DCO_MON_EN_O,
  output logic [3:0]       OUT_DIV_LOG2_O,
  output logic [1:0]       MODE_STATE_O,
  output logic             DCO_STABLE_O
);
  import clkgen_pkg::*;

  localparam state_type ST_RST = '{
    mode: M_SCM, cms: CMS_RST, reduced_divider: RFD_RST, trim: TRIM_POR,
    filt: FILT_RST, bresp: RESP_OKAY, rresp: RESP_OKAY, default: '0};

  state_type s_r;
  state_type s_nxt;

  logic        stop_off;
  logic        ext_ok;
  logic        do_write;
  logic [15:0] err_diff;
  logic [15:0] err_abs;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  function automatic logic [1:0] mode_code(input mode_type m);
    unique case (m)
      M_SCM:   mode_code = CMS_SCM;
      M_FEI:   mode_code = CMS_FEI;
      M_FBE:   mode_code = CMS_FBE;
      M_FEE:   mode_code = CMS_FEE;
      default: mode_code = CMS_SCM;
    endcase
  endfunction : mode_code

  // Crystal needs the start-up count, a plain clock is usable at once
  assign ext_ok   = EXT_REF_STABLE_FLAG_I && (!XTAL_I || (s_r.xtal_cnt == XTAL_COUNT));
  assign stop_off = STOP_I && !BDM_EN_I && !s_r.osten;
  assign do_write = s_r.aw_hold && s_r.w_hold && !s_r.bvalid;
  assign err_diff = COUNT_ERR_I - s_r.prev_err;
  assign err_abs  = err_diff[15] ? 16'(-err_diff) : err_diff;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (S_AXI_ARADDR)
      OFS_CTRL:
      begin
        rd_byte[CTRL_CMS_LSB +: 2] = s_r.cms;
        rd_byte[CTRL_OSTEN]        = s_r.osten;
        rd_byte[CTRL_RFD_LSB +: 3] = s_r.reduced_divider;
      end
      OFS_STATUS:
      begin
        rd_byte[STAT_DCO_STABLE_FLAG]          = s_r.dco_stable_flag;
        rd_byte[STAT_EXT_REF_STABLE_FLAG]          = EXT_REF_STABLE_FLAG_I;
        rd_byte[STAT_LOSS_OF_CLOCK_FLAG]          = LOSS_OF_CLOCK_FLAG_I;
        rd_byte[STAT_CMST_LSB +: 2] = s_r.st_sync2;
      end
      OFS_FILT_UP: rd_byte = {4'h0, s_r.filt[11:8]};
      OFS_FILT_LO: rd_byte = s_r.filt[7:0];
      OFS_TRIM:    rd_byte = s_r.trim;
      default:     rd_hit  = 1'b0;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;

    // Register slave: address and data may arrive in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      s_nxt.w_hold  = 1'b1;
      s_nxt.w_data  = S_AXI_WDATA[7:0];
      s_nxt.w_lane0 = S_AXI_WSTRB[0];
    end
    if (s_r.bvalid && S_AXI_BREADY)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && S_AXI_RREADY)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {24'h000000, rd_byte};
      s_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Filter settle countdown and closed-loop filter updates
    if (s_r.flt_busy != 3'h0)
    begin
      s_nxt.flt_busy = s_r.flt_busy - 3'h1;
    end
    if (LOOP_UPD_I && (s_r.mode == M_FEI || s_r.mode == M_FEE))
    begin
      s_nxt.filt = LOOP_FILT_I;
    end

    if (do_write)
    begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      unique case (s_r.aw_addr)
        OFS_CTRL:
        begin
          if (s_r.w_lane0)
          begin
            s_nxt.cms   = s_r.w_data[CTRL_CMS_LSB +: 2];
            s_nxt.osten = s_r.w_data[CTRL_OSTEN];
            s_nxt.reduced_divider   = s_r.w_data[CTRL_RFD_LSB +: 3];
          end
        end
        OFS_STATUS:
        begin
          s_nxt.bresp = RESP_OKAY;
        end
        OFS_FILT_LO:
        begin
          if (s_r.w_lane0 && s_r.cms == CMS_SCM)
          begin
            s_nxt.filt_lo_stage = s_r.w_data;
          end
        end
        OFS_FILT_UP:
        begin
          // Busy window keeps the DIGITAL_OSC from seeing back-to-back steps
          if (s_r.w_lane0 && s_r.cms == CMS_SCM && s_r.flt_busy == 3'h0)
          begin
            s_nxt.filt     = {s_r.w_data[3:0], s_r.filt_lo_stage};
            s_nxt.flt_busy = FLT_SETTLE;
          end
        end
        OFS_TRIM:
        begin
          if (s_r.w_lane0)
          begin
            s_nxt.trim = s_r.w_data;
          end
        end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // DIGITAL_OSC stability from successive count-error samples
    if (SAMPLE_I && s_r.mode != M_OFF)
    begin
      s_nxt.prev_err = COUNT_ERR_I;
      if (err_abs <= N_UNLOCK && DCO_ACTIVE_I)
      begin
        if (s_r.good_cnt != 2'h2)
        begin
          s_nxt.good_cnt = s_r.good_cnt + 2'h1;
        end
        if (s_r.good_cnt != 2'h0)
        begin
          s_nxt.dco_stable_flag = 1'b1;
        end
      end
      else
      begin
        s_nxt.good_cnt = 2'h0;
        s_nxt.dco_stable_flag     = 1'b0;
      end
    end

    // Crystal start-up count
    if (REF_EDGE_I && XTAL_I && s_r.xtal_cnt != XTAL_COUNT)
    begin
      s_nxt.xtal_cnt = s_r.xtal_cnt + 13'h0001;
    end

    // Halved output is only for the first lock attempt in external engaged
    if (s_r.mode == M_FEE && LOCK_I)
    begin
      s_nxt.locked_once = 1'b1;
    end
    if (s_r.mode != M_FEE)
    begin
      s_nxt.locked_once = 1'b0;
    end

    // Mode machine
    if (s_r.mode == M_OFF)
    begin
      if (!STOP_I)
      begin
        if (s_r.cms == CMS_FBE && EXT_REF_STABLE_FLAG_I)
        begin
          s_nxt.mode = M_FBE;
        end
        else
        begin
          s_nxt.mode     = M_SCM;
          s_nxt.from_off = 1'b1;
        end
      end
    end
    else if (stop_off)
    begin
      s_nxt.mode     = M_OFF;
      s_nxt.dco_stable_flag     = 1'b0;
      s_nxt.good_cnt = 2'h0;
      s_nxt.xtal_cnt = 13'h0000;
    end
    else if (s_r.cms[1] && !EXT_REF_STABLE_FLAG_I && LOSS_OF_CLOCK_FLAG_I)
    begin
      s_nxt.mode = M_SCM;
    end
    else
    begin
      unique case (s_r.mode)
        M_SCM:
        begin
          if (s_r.cms == CMS_FEI && (!s_r.from_off || s_r.dco_stable_flag))
          begin
            s_nxt.mode = M_FEI;
          end
          else if (s_r.cms == CMS_FEE && EXT_REF_STABLE_FLAG_I && s_r.dco_stable_flag)
          begin
            s_nxt.mode = M_FEE;
          end
          else if (s_r.cms == CMS_FBE && EXT_REF_STABLE_FLAG_I)
          begin
            s_nxt.mode = M_FBE;
          end
        end
        M_FEI:
        begin
          if (s_r.cms == CMS_SCM)
          begin
            s_nxt.mode = M_SCM;
          end
          else if (s_r.cms == CMS_FEE && EXT_REF_STABLE_FLAG_I && s_r.dco_stable_flag)
          begin
            s_nxt.mode = M_FEE;
          end
          else if (s_r.cms == CMS_FBE && EXT_REF_STABLE_FLAG_I)
          begin
            s_nxt.mode = M_FBE;
          end
        end
        M_FBE:
        begin
          if (s_r.cms == CMS_SCM)
          begin
            s_nxt.mode = M_SCM;
          end
          else if (s_r.cms == CMS_FEI)
          begin
            s_nxt.mode = M_FEI;
          end
          else if (s_r.cms == CMS_FEE && s_r.dco_stable_flag)
          begin
            s_nxt.mode = M_FEE;
          end
        end
        M_FEE:
        begin
          if (LOSS_OF_CLOCK_FLAG_I && EXT_REF_STABLE_FLAG_I)
          begin
            s_nxt.mode = M_FBE;
          end
          else if (s_r.cms == CMS_SCM)
          begin
            s_nxt.mode = M_SCM;
          end
          else if (s_r.cms == CMS_FEI)
          begin
            s_nxt.mode = M_FEI;
          end
          else if (s_r.cms == CMS_FBE)
          begin
            s_nxt.mode = M_FBE;
          end
        end
        default: s_nxt.mode = M_SCM;
      endcase
    end
    if (s_nxt.mode != M_SCM)
    begin
      s_nxt.from_off = 1'b0;
    end

    // Mode state lags the mode by two registers
    if (s_r.mode != M_OFF)
    begin
      s_nxt.st_sync1 = mode_code(s_r.mode);
    end
    s_nxt.st_sync2 = s_r.st_sync1;

    // Reset restores defaults but keeps trim; only power-on reloads it
    if (RESET_I)
    begin
      s_nxt      = ST_RST;
      s_nxt.trim = s_r.trim;
    end
    if (POR_I)
    begin
      s_nxt = ST_RST;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    s_r <= s_nxt;
  end

  assign S_AXI_AWREADY  = !s_r.aw_hold && !s_r.bvalid;
  assign S_AXI_WREADY   = !s_r.w_hold && !s_r.bvalid;
  assign S_AXI_BVALID   = s_r.bvalid;
  assign S_AXI_BRESP    = s_r.bresp;
  assign S_AXI_ARREADY  = !s_r.rvalid;
  assign S_AXI_RVALID   = s_r.rvalid;
  assign S_AXI_RDATA    = s_r.rdata;
  assign S_AXI_RRESP    = s_r.rresp;

  assign FILTER_O       = s_r.filt;
  assign TRIM_O         = s_r.trim;
  // FBE turns the DIGITAL_OSC off; off turns everything off
  assign DCO_EN_O       = s_r.mode != M_OFF && s_r.mode != M_FBE;
  assign REF_GEN_EN_O   = s_r.mode != M_OFF;
  assign SYS_CLK_EN_O   = !(STOP_I && !BDM_EN_I) && s_r.mode != M_OFF;
  assign OUT_EN_O       = !(s_r.mode == M_FBE && !ext_ok) && s_r.mode != M_OFF;
  assign REF_SEL_EXT_O  = (s_r.mode == M_FEE || s_r.mode == M_FBE) && ext_ok;
  assign LOOP_CLOSED_O  = s_r.mode == M_FEI || s_r.mode == M_FEE;
  assign DCO_MON_EN_O   = (s_r.mode == M_SCM) ? s_r.dco_stable_flag : LOOP_CLOSED_O;
  assign OUT_DIV_LOG2_O = {1'b0, s_r.reduced_divider}
                          + {3'h0, s_r.mode == M_FEE && !s_r.locked_once};
  assign MODE_STATE_O   = s_r.st_sync2;
  assign DCO_STABLE_O   = s_r.dco_stable_flag;
endmodule : clkgen_ctrl

// ---- tb/clkgen_ctrl_monitor.sv ----
// Checker for the clock generator control block
`timescale 1ns/10ps
module clkgen_ctrl_monitor (
  input wire logic       REF_CLK_I,
  input wire logic       RESET_I,
  input wire logic       POR_I,
  input wire logic       STOP_I,
  input wire logic       BDM_EN_I,
  input wire logic       EXT_REF_STABLE_FLAG_I,
  input wire logic       SAMPLE_I,
  input wire logic       DCO_ACTIVE_I,
  input wire logic       DCO_EN_O,
  input wire logic       REF_GEN_EN_O,
  input wire logic       SYS_CLK_EN_O,
  input wire logic       OUT_EN_O,
  input wire logic       LOOP_CLOSED_O,
  input wire logic       DCO_MON_EN_O,
  input wire logic [1:0] MODE_STATE_O,
  input wire logic       DCO_STABLE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I || POR_I);
  // Mode decoded from enables, state field lags two edges
  wire self_clocked_mode = DCO_EN_O && !LOOP_CLOSED_O;
  wire fbe = REF_GEN_EN_O && !DCO_EN_O;
  sequence s_off2; !REF_GEN_EN_O [*2]; endsequence
  sequence s_scm3; self_clocked_mode [*3]; endsequence
  sequence s_fbe3; fbe [*3]; endsequence
  property p_off_dco_stable_flag; s_off2 |-> !DCO_STABLE_O; endproperty
  a_off_dco_stable_flag: assert property (p_off_dco_stable_flag) else $error("stable flag set while off");
  property p_off_out; !REF_GEN_EN_O |-> !OUT_EN_O && !SYS_CLK_EN_O && !DCO_EN_O; endproperty
  a_off_out: assert property (p_off_out) else $error("clock active while off");
  property p_stop_gate; STOP_I && !BDM_EN_I |-> !SYS_CLK_EN_O; endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("clock feed open in stop");
  property p_bdm_run; STOP_I && BDM_EN_I && REF_GEN_EN_O |=> REF_GEN_EN_O; endproperty
  a_bdm_run: assert property (p_bdm_run) else $error("debug stop halted clocks");
  property p_dco_stable_flag_set; $rose(DCO_STABLE_O) |-> $past(SAMPLE_I) && $past(DCO_ACTIVE_I); endproperty
  a_dco_stable_flag_set: assert property (p_dco_stable_flag_set) else $error("stable flag without good sample");
  property p_mon_scm; self_clocked_mode |-> DCO_MON_EN_O == DCO_STABLE_O; endproperty
  a_mon_scm: assert property (p_mon_scm) else $error("monitor enable wrong in scm");
  property p_state_scm; s_scm3 |-> MODE_STATE_O == 2'h0; endproperty
  a_state_scm: assert property (p_state_scm) else $error("state not scm");
  property p_state_fbe; s_fbe3 |-> MODE_STATE_O == 2'h2; endproperty
  a_state_fbe: assert property (p_state_fbe) else $error("state not bypassed");
  property p_fbe_out; (fbe && !EXT_REF_STABLE_FLAG_I) [*2] |-> !OUT_EN_O; endproperty
  a_fbe_out: assert property (p_fbe_out) else $error("output on before external ok");
  property p_closed; LOOP_CLOSED_O [*3] |-> MODE_STATE_O[0]; endproperty
  a_closed: assert property (p_closed) else $error("state not engaged");
endmodule : clkgen_ctrl_monitor
bind clkgen_ctrl clkgen_ctrl_monitor u_mon (.*);

// ---- tb/clkgen_ctrl_tb_top.sv ----
// Self-checking bench for the clock generator control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module clkgen_ctrl_tb_top;
  import clkgen_pkg::*;
  logic REF_CLK_I, RESET_I, POR_I, STOP_I, BDM_EN_I, EXT_REF_STABLE_FLAG_I, LOSS_OF_CLOCK_FLAG_I, LOCK_I, XTAL_I;
  logic REF_EDGE_I, SAMPLE_I, DCO_ACTIVE_I, LOOP_UPD_I;
  logic [15:0] COUNT_ERR_I;
  logic [11:0] LOOP_FILT_I, FILTER_O;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, TRIM_O;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB, OUT_DIV_LOG2_O;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, MODE_STATE_O;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic DCO_EN_O, REF_GEN_EN_O, SYS_CLK_EN_O, OUT_EN_O, REF_SEL_EXT_O, LOOP_CLOSED_O;
  logic DCO_MON_EN_O, DCO_STABLE_O;
  logic [31:0] d;
  logic [1:0]  r;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  clkgen_ctrl u_dut (.*);
  initial
  begin
    REF_CLK_I = 0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard well above the run length
  always @(posedge REF_CLK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      wrap_up();
    end
  end
  task tk(input int n);
    repeat (n) @(posedge REF_CLK_I);
  endtask : tk
  // Channels released independently, response held until taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ar, wr_r;
    S_AXI_AWADDR <= a; S_AXI_WDATA <= v; S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    #1;
    while (S_AXI_AWVALID || S_AXI_WVALID)
    begin
      ar = S_AXI_AWREADY && S_AXI_AWVALID;
      wr_r = S_AXI_WREADY && S_AXI_WVALID;
      @(posedge REF_CLK_I);
      if (ar) S_AXI_AWVALID <= 0;
      if (wr_r) S_AXI_WVALID <= 0;
      #1;
    end
    while (!S_AXI_BVALID) begin @(posedge REF_CLK_I); #1; end
    r = S_AXI_BRESP;
    @(posedge REF_CLK_I);
    S_AXI_BREADY <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= 1;
    #1;
    while (!S_AXI_ARREADY) begin @(posedge REF_CLK_I); #1; end
    @(posedge REF_CLK_I);
    S_AXI_ARVALID <= 0;
    #1;
    while (!S_AXI_RVALID) begin @(posedge REF_CLK_I); #1; end
    d = S_AXI_RDATA; r = S_AXI_RRESP;
    @(posedge REF_CLK_I);
    S_AXI_RREADY <= 0;
  endtask : rd
  task samp(input logic [15:0] e);
    SAMPLE_I <= 1; COUNT_ERR_I <= e;
    tk(1);
    SAMPLE_I <= 0;
    tk(1);
  endtask : samp
  task t_rst;
    `CHK("filter out", 12'h800, FILTER_O)
    `CHK("trim out", 8'h80, TRIM_O)
    `CHK("mon", 1'b0, DCO_MON_EN_O)
    rd(OFS_CTRL); `CHK("ctrl", 32'h0, d)
    rd(OFS_FILT_UP); `CHK("filt up", 32'h8, d)
    rd(OFS_STATUS); `CHK("status", 32'h0, d)
    rd(8'h14); `CHK("bad resp", RESP_SLVERR, r)
    `CHK("bad data", 32'h0, d)
    wr(8'h14, 32'h0); `CHK("bad wr resp", RESP_SLVERR, r)
    wr(OFS_STATUS, 32'hff); `CHK("status wr resp", RESP_OKAY, r)
  endtask : t_rst
  task t_filt;
    // Small filter steps keep the DIGITAL_OSC under its rating
    wr(OFS_FILT_LO, 32'h3c); wr(OFS_FILT_UP, 32'h5);
    `CHK("filter", 12'h53c, FILTER_O)
    wr(OFS_FILT_UP, 32'ha); `CHK("filter early", 12'h53c, FILTER_O)
    tk(8); wr(OFS_FILT_UP, 32'ha); `CHK("filter late", 12'ha3c, FILTER_O)
    rd(OFS_FILT_LO); `CHK("filt lo", 32'h3c, d)
  endtask : t_filt
  task t_mode;
    wr(OFS_CTRL, 32'h1); tk(4);
    `CHK("fei state", 2'h1, MODE_STATE_O)
    wr(OFS_FILT_LO, 32'h11); wr(OFS_FILT_UP, 32'h1);
    `CHK("filter ro", 12'ha3c, FILTER_O)
    wr(OFS_CTRL, 32'h71); `CHK("div", 4'h7, OUT_DIV_LOG2_O)
    wr(OFS_CTRL, 32'h0); tk(4);
    `CHK("scm back", 1'b0, LOOP_CLOSED_O)
    `CHK("scm state", 2'h0, MODE_STATE_O)
  endtask : t_mode
  task t_stop;
    wr(OFS_CTRL, 32'h1);
    DCO_ACTIVE_I <= 0; samp(16'h5); samp(16'h5);
    `CHK("static", 1'b0, DCO_STABLE_O)
    DCO_ACTIVE_I <= 1; samp(16'h5); samp(16'h5);
    `CHK("stable", 1'b1, DCO_STABLE_O)
    STOP_I <= 1; tk(2);
    `CHK("off", 1'b0, REF_GEN_EN_O)
    `CHK("off dco_stable_flag", 1'b0, DCO_STABLE_O)
    STOP_I <= 0; tk(3);
    `CHK("wait dco_stable_flag", 1'b0, LOOP_CLOSED_O)
    samp(16'h5); samp(16'h5); tk(1);
    `CHK("closed", 1'b1, LOOP_CLOSED_O)
    rd(OFS_CTRL); `CHK("kept", 32'h1, d)
    BDM_EN_I <= 1; STOP_I <= 1; tk(3);
    `CHK("bdm run", 1'b1, REF_GEN_EN_O)
    `CHK("bdm feed", 1'b1, SYS_CLK_EN_O)
    STOP_I <= 0; BDM_EN_I <= 0; wr(OFS_CTRL, 32'h5); STOP_I <= 1; tk(3);
    `CHK("osten run", 1'b1, REF_GEN_EN_O)
    `CHK("osten feed", 1'b0, SYS_CLK_EN_O)
    STOP_I <= 0; tk(2);
  endtask : t_stop
  task t_fbe;
    EXT_REF_STABLE_FLAG_I <= 1; wr(OFS_CTRL, 32'h2); tk(4);
    `CHK("fbe dco", 1'b0, DCO_EN_O)
    `CHK("fbe state", 2'h2, MODE_STATE_O)
    EXT_REF_STABLE_FLAG_I <= 0; tk(3); `CHK("fbe out", 1'b0, OUT_EN_O)
    LOSS_OF_CLOCK_FLAG_I <= 1; tk(4); `CHK("lost ref", 2'h0, MODE_STATE_O)
    LOSS_OF_CLOCK_FLAG_I <= 0;
  endtask : t_fbe
  task t_trim;
    wr(OFS_TRIM, 32'h5a); `CHK("trim", 8'h5a, TRIM_O)
    wr(OFS_CTRL, 32'h1); STOP_I <= 1; tk(2);
    RESET_I <= 1; tk(2); STOP_I <= 0; RESET_I <= 0; tk(1);
    `CHK("trim kept", 8'h5a, TRIM_O)
    `CHK("reset scm", 1'b0, LOOP_CLOSED_O)
    `CHK("reset filt", 12'h800, FILTER_O)
    rd(OFS_CTRL); `CHK("reset ctrl", 32'h0, d)
    POR_I <= 1; tk(2); POR_I <= 0; tk(1);
    `CHK("por trim", 8'h80, TRIM_O)
  endtask : t_trim
  // Crystal reference: external engaged closes the loop at once, external select waits for the start-up count
  task t_xtal;
    XTAL_I <= 1; EXT_REF_STABLE_FLAG_I <= 1; DCO_ACTIVE_I <= 1;
    samp(16'h5); samp(16'h5);
    wr(OFS_CTRL, 32'h3); tk(4);
    `CHK("fee closed", 1'b1, LOOP_CLOSED_O)
    `CHK("fee state", 2'h3, MODE_STATE_O)
    `CHK("fee mon", 1'b1, DCO_MON_EN_O)
    `CHK("fee halved", 4'h1, OUT_DIV_LOG2_O)
    `CHK("xtal wait", 1'b0, REF_SEL_EXT_O)
    REF_EDGE_I <= 1; tk(4095); REF_EDGE_I <= 0; tk(2);
    `CHK("xtal 4095", 1'b0, REF_SEL_EXT_O)
    REF_EDGE_I <= 1; tk(1); REF_EDGE_I <= 0; tk(2);
    `CHK("xtal 4096", 1'b1, REF_SEL_EXT_O)
    LOOP_FILT_I <= 12'h123; LOOP_UPD_I <= 1; tk(1); LOOP_UPD_I <= 0; tk(1);
    `CHK("loop filt", 12'h123, FILTER_O)
    LOCK_I <= 1; tk(2); LOCK_I <= 0; tk(1);
    `CHK("locked div", 4'h0, OUT_DIV_LOG2_O)
    wr(OFS_CTRL, 32'h0); tk(4);
    `CHK("scm from fee", 2'h0, MODE_STATE_O)
    `CHK("scm mon", 1'b1, DCO_MON_EN_O)
  endtask : t_xtal
  initial
  begin
    RESET_I = 1; POR_I = 1; STOP_I = 0; BDM_EN_I = 0; EXT_REF_STABLE_FLAG_I = 0; LOSS_OF_CLOCK_FLAG_I = 0;
    LOCK_I = 0; XTAL_I = 0; REF_EDGE_I = 0; SAMPLE_I = 0; DCO_ACTIVE_I = 1;
    LOOP_UPD_I = 0; COUNT_ERR_I = 0; LOOP_FILT_I = 0; S_AXI_AWADDR = 0; S_AXI_ARADDR = 0;
    S_AXI_WDATA = 0; S_AXI_WSTRB = 4'hf; S_AXI_AWVALID = 0; S_AXI_WVALID = 0;
    S_AXI_BREADY = 0; S_AXI_ARVALID = 0; S_AXI_RREADY = 0;
    tk(16);
    RESET_I <= 0; POR_I <= 0;
    tk(1);
    t_rst(); t_filt(); t_mode(); t_stop(); t_fbe(); t_trim(); t_xtal();
    wrap_up();
  end
endmodule : clkgen_ctrl_tb_top
